// ---- rtl/tic_pkg.sv ----
// Purpose: Shared constants and types for the timer input capture block
// Assumes: Single core_clk domain, plain register port
// Notes:   Offsets are byte addresses on the register port
package tic_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int COUNT_W = 25;
    localparam int DMA_AW  = 15;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_END      = 8'h04;
    localparam logic [7:0] OFS_QUEUE    = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_MASK     = 8'h10;
    localparam logic [7:0] OFS_DMA_CTRL = 8'h14;
    localparam logic [7:0] OFS_DMA_BEG  = 8'h18;
    localparam logic [7:0] OFS_DMA_STOP = 8'h1C;
    localparam logic [7:0] OFS_DMA_CUR  = 8'h20;
    localparam logic [7:0] OFS_LEVEL    = 8'h24;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_CLEAR_ALL = 0;
    localparam int BIT_RUN       = 1;
    localparam int BIT_CAPTURE   = 2;
    localparam int BIT_EDGE_LO   = 3;
    localparam int BIT_DMA_EN    = 0;
    localparam int BIT_DMA_WRAP  = 2;
    localparam int EV_DATA       = 0;
    localparam int EV_TIMEOUT    = 1;
    localparam int EV_LOST       = 2;
    localparam int EV_W          = 3;
    localparam int DMA_STEP      = 4;

    // Capture edge select codes
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_ANY  = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_RISE = 2'h3;

    // Reset values
    localparam logic [COUNT_W-1:0] END_RESET  = 25'h0000000;
    localparam logic [EV_W-1:0]    MASK_RESET = 3'h0;
    localparam logic [DMA_AW-1:0]  ADDR_RESET = 15'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [1:0] capture_edge_select;
        logic       input_mode_select;
        logic       counter_run_enable;
        logic       clear_all_control;
    } tic_mode_type;

    typedef struct packed {
        logic               marker;
        logic [COUNT_W-1:0] count;
    } tic_word_type;

endpackage

// ---- rtl/tic_meas.sv ----
// Purpose: Synchronises the capture pin and measures widths or periods
// Assumes: Pin is asynchronous to core_clk
// Notes:   Words start after the first qualifying edge once enabled
`timescale 1ns/1ps
module tic_meas
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       cap_pin,
    input  wire logic                       enable,
    input  wire logic [1:0]                 edge_mode,
    input  wire logic [tic_pkg::COUNT_W-1:0] end_value,
    output logic                            word_valid,
    output tic_pkg::tic_word_type           word,
    output logic                            timeout_pulse
);
    logic                        sync_a;
    logic                        sync_b;
    logic                        level_prev;
    logic                        armed;
    logic                        next_armed;
    logic [tic_pkg::COUNT_W-1:0] count;
    logic [tic_pkg::COUNT_W-1:0] next_count;
    logic [tic_pkg::COUNT_W-1:0] tick;
    logic                        hit;
    logic                        next_valid;
    logic                        next_timeout;
    tic_pkg::tic_word_type       next_word;

    ////////////////////////////////////////////////////////////////////////
    // Edge qualification, counting and word forming
    always_comb
    begin
        tick         = count + 25'h0000001;
        next_count   = tick; // R5
        next_armed   = armed;
        next_valid   = 1'b0;
        next_timeout = 1'b0;
        next_word    = word;
        case (edge_mode) // R1
            tic_pkg::EDGE_ANY:  hit = sync_b ^ level_prev;
            tic_pkg::EDGE_FALL: hit = level_prev & ~sync_b;
            tic_pkg::EDGE_RISE: hit = sync_b & ~level_prev;
            default:            hit = 1'b0;
        endcase
        if (!enable)
        begin
            next_count = '0; // R7
            next_armed = 1'b0;
        end
        else if (hit)
        begin
            next_count = '0; // R15
            next_armed = 1'b1;
            if (armed)
            begin
                next_valid        = 1'b1;
                next_word.count   = tick;
                // Ended level in any-edge mode, normal period otherwise
                next_word.marker  = (edge_mode == tic_pkg::EDGE_ANY) & level_prev; // R2 R4
            end
        end
        else if (armed && end_value != '0 && tick == end_value)
        begin
            next_count       = '0; // R15
            next_valid       = 1'b1; // R6
            next_timeout     = 1'b1;
            next_word.count  = tick;
            // Same level continues, or period overrun
            next_word.marker = (edge_mode == tic_pkg::EDGE_ANY) ? sync_b : 1'b1; // R3 R4
        end
        else if (!armed)
        begin
            next_count = '0;
        end
    end

    // Pin synchroniser and state registers
    always_ff @(posedge core_clk)
    begin
        sync_a     <= cap_pin;
        sync_b     <= sync_a;
        level_prev <= sync_b; // R5
        if (!rst_n)
        begin
            count         <= '0;
            armed         <= 1'b0;
            word_valid    <= 1'b0;
            timeout_pulse <= 1'b0;
            word          <= '0;
        end
        else
        begin
            count         <= next_count;
            armed         <= next_armed;
            word_valid    <= next_valid;
            timeout_pulse <= next_timeout;
            word          <= next_word;
        end
    end

endmodule

// ---- rtl/tic_dma.sv ----
// Purpose: Stores captured words into a memory buffer
// Assumes: Addresses already masked to 15 bits and word aligned
// Notes:   One word in flight; refuses input while busy or at stop
`timescale 1ns/1ps
module tic_dma
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       enable,
    input  wire logic                       wrap,
    input  wire logic [tic_pkg::DMA_AW-1:0] start_addr,
    input  wire logic [tic_pkg::DMA_AW-1:0] stop_addr,
    input  wire logic                       in_valid,
    input  wire logic [tic_pkg::DATA_W-1:0] in_word,
    output logic                            in_ready,
    output logic                            mem_wr_valid,
    output logic [tic_pkg::DMA_AW-1:0]      mem_wr_addr,
    output logic [tic_pkg::DATA_W-1:0]      mem_wr_data,
    input  wire logic                       mem_wr_ready
);
    logic                       busy;
    logic                       next_busy;
    logic [tic_pkg::DMA_AW-1:0] next_addr;
    logic [tic_pkg::DMA_AW-1:0] step;
    logic [tic_pkg::DATA_W-1:0] next_data;

    ////////////////////////////////////////////////////////////////////////
    // Pointer advance and write hand-off
    always_comb
    begin
        step      = mem_wr_addr + tic_pkg::DMA_AW'(tic_pkg::DMA_STEP);
        in_ready  = enable & ~busy & (mem_wr_addr != stop_addr); // R11
        next_busy = busy;
        next_addr = mem_wr_addr;
        next_data = mem_wr_data;
        if (!enable)
        begin
            next_busy = 1'b0; // R11
            next_addr = start_addr;
        end
        else if (busy)
        begin
            if (mem_wr_ready)
            begin
                next_busy = 1'b0;
                next_addr = (wrap && step == stop_addr) ? start_addr : step; // R13
            end
        end
        else if (in_valid && in_ready)
        begin
            next_busy = 1'b1; // R10
            next_data = in_word;
        end
    end

    // Registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            busy        <= 1'b0;
            mem_wr_addr <= tic_pkg::ADDR_RESET;
            mem_wr_data <= '0;
        end
        else
        begin
            busy        <= next_busy;
            mem_wr_addr <= next_addr;
            mem_wr_data <= next_data;
        end
    end

    assign mem_wr_valid = busy;

endmodule

// ---- rtl/tic_top.sv ----
// Purpose: Timer input capture with data queue, interrupts and DMA
// Assumes: Register port reads return data in the following cycle
// Notes:   DMA_CAPABLE set only on the first and second timer instances
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
// How it works
// R1: Edge select: 00 off, 01 any edge, 10 fall to fall, 11 rise to rise.
// R2: Any-edge words mark bit 25 high for high level, low for low.
// R3: Any-edge levels beyond timeout give repeated words with same marker.
// R4: Same-edge modes: bit 25 low normally, high for timeout periods.
// R5: Pin sampled every clock; widths counted in clock cycles.
// R6: Count reaching end value raises timeout flag and marked timeout word.
// R7: Clear-all empties queue, clears flags; capture needs clear off, mode, run.
// R8: Software sets end value, mode, edge, run, and optionally interrupts.
// R9: Every captured word sets data flag; interrupt if enabled.
// R10: Without DMA words enter the queue; with DMA they go to memory.
// R11: DMA writes start up to but excluding stop, only while enabled.
// R12: Only the first two timer instances support DMA storage.
// R13: With wrap on, reaching stop returns pointer to start.
// R14: DMA addresses use 15 low bits, word aligned; current address readable.
// R15: Counter restarts from zero after every capture or timeout word.
// R16: Words are 26 bits: marker bit 25, count below, zero extended.
module tic_top
#(
    parameter bit DMA_CAPABLE = 1'b1,
    parameter int QUEUE_DEPTH = 8
)
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic [tic_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [tic_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [tic_pkg::DATA_W-1:0]      reg_rdata,
    input  wire logic                       cap_pin,
    output logic                            irq,
    output logic                            mem_wr_valid,
    output logic [tic_pkg::DMA_AW-1:0]      mem_wr_addr,
    output logic [tic_pkg::DATA_W-1:0]      mem_wr_data,
    input  wire logic                       mem_wr_ready
);
    localparam int PTR_W = $clog2(QUEUE_DEPTH);
    localparam int LVL_W = $clog2(QUEUE_DEPTH + 1);
    localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(QUEUE_DEPTH);

    // Configuration
    tic_pkg::tic_mode_type       mode;
    tic_pkg::tic_mode_type       next_mode;
    logic [tic_pkg::COUNT_W-1:0] end_value;
    logic [tic_pkg::COUNT_W-1:0] next_end_value;
    logic [tic_pkg::EV_W-1:0]    int_mask;
    logic [tic_pkg::EV_W-1:0]    next_int_mask;
    logic                        dma_en;
    logic                        next_dma_en;
    logic                        dma_wrap;
    logic                        next_dma_wrap;
    logic [tic_pkg::DMA_AW-1:0]  dma_beg;
    logic [tic_pkg::DMA_AW-1:0]  next_dma_beg;
    logic [tic_pkg::DMA_AW-1:0]  dma_stop;
    logic [tic_pkg::DMA_AW-1:0]  next_dma_stop;

    // Queue
    tic_pkg::tic_word_type       queue_mem [QUEUE_DEPTH];
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            next_wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [PTR_W-1:0]            next_rd_ptr;
    logic [LVL_W-1:0]            level;
    logic [LVL_W-1:0]            next_level;
    logic                        push;
    logic                        pop;

    // Status and read path
    logic [tic_pkg::EV_W-1:0]    int_status;
    logic [tic_pkg::EV_W-1:0]    next_int_status;
    logic [tic_pkg::EV_W-1:0]    events;
    logic [tic_pkg::DATA_W-1:0]  next_rdata;

    // Measurement and DMA links
    logic                        meas_en;
    logic                        word_valid;
    tic_pkg::tic_word_type       word;
    logic                        timeout_pulse;
    logic                        dma_active;
    logic                        dma_in_ready;
    logic                        lost;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Word aligned 15-bit address from write data
    function automatic logic [tic_pkg::DMA_AW-1:0] align_addr(
        input logic [tic_pkg::DATA_W-1:0] value);
        align_addr = {value[tic_pkg::DMA_AW-1:2], 2'h0};
    endfunction

    // Zero extend a captured word to the bus width
    function automatic logic [tic_pkg::DATA_W-1:0] word_to_bus(
        input tic_pkg::tic_word_type value);
        word_to_bus = tic_pkg::DATA_W'(value); // R16
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_comb
    begin
        next_mode      = mode;
        next_end_value = end_value;
        next_int_mask  = int_mask;
        next_dma_en    = dma_en;
        next_dma_wrap  = dma_wrap;
        next_dma_beg   = dma_beg;
        next_dma_stop  = dma_stop;
        if (reg_wr)
        begin
            if (reg_addr == tic_pkg::OFS_MODE)
            begin
                next_mode = reg_wdata[tic_pkg::BIT_EDGE_LO+1:0];
            end
            else if (reg_addr == tic_pkg::OFS_END)
            begin
                next_end_value = reg_wdata[tic_pkg::COUNT_W-1:0];
            end
            else if (reg_addr == tic_pkg::OFS_MASK)
            begin
                next_int_mask = reg_wdata[tic_pkg::EV_W-1:0];
            end
            else if (reg_addr == tic_pkg::OFS_DMA_CTRL && DMA_CAPABLE)
            begin
                next_dma_en   = reg_wdata[tic_pkg::BIT_DMA_EN]; // R12
                next_dma_wrap = reg_wdata[tic_pkg::BIT_DMA_WRAP];
            end
            else if (reg_addr == tic_pkg::OFS_DMA_BEG && DMA_CAPABLE)
            begin
                next_dma_beg = align_addr(reg_wdata); // R14
            end
            else if (reg_addr == tic_pkg::OFS_DMA_STOP && DMA_CAPABLE)
            begin
                next_dma_stop = align_addr(reg_wdata); // R14
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            mode      <= '0;
            end_value <= tic_pkg::END_RESET;
            int_mask  <= tic_pkg::MASK_RESET;
            dma_en    <= 1'b0;
            dma_wrap  <= 1'b0;
            dma_beg   <= tic_pkg::ADDR_RESET;
            dma_stop  <= tic_pkg::ADDR_RESET;
        end
        else
        begin
            mode      <= next_mode;
            end_value <= next_end_value;
            int_mask  <= next_int_mask;
            dma_en    <= next_dma_en;
            dma_wrap  <= next_dma_wrap;
            dma_beg   <= next_dma_beg;
            dma_stop  <= next_dma_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement engine and word routing

    // Capture runs only with clear off, capture mode and run set
    assign meas_en = ~mode.clear_all_control & mode.input_mode_select
                   & mode.counter_run_enable; // R7

    tic_meas u_meas
    (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .cap_pin       (cap_pin),
        .enable        (meas_en),
        .edge_mode     (mode.capture_edge_select),
        .end_value     (end_value),
        .word_valid    (word_valid),
        .word          (word),
        .timeout_pulse (timeout_pulse)
    );

    assign dma_active = DMA_CAPABLE & dma_en; // R12

    tic_dma u_dma
    (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .enable       (dma_active),
        .wrap         (dma_wrap),
        .start_addr   (dma_beg),
        .stop_addr    (dma_stop),
        .in_valid     (word_valid & dma_active),
        .in_word      (word_to_bus(word)),
        .in_ready     (dma_in_ready),
        .mem_wr_valid (mem_wr_valid),
        .mem_wr_addr  (mem_wr_addr),
        .mem_wr_data  (mem_wr_data),
        .mem_wr_ready (mem_wr_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // Capture data queue
    always_comb
    begin
        push        = word_valid & ~dma_active & (level != FULL_LVL); // R10
        pop         = reg_rd & (reg_addr == tic_pkg::OFS_QUEUE) & (level != '0);
        lost        = word_valid & (dma_active ? ~dma_in_ready : (level == FULL_LVL));
        next_wr_ptr = push ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
        next_level  = level + LVL_W'(push) - LVL_W'(pop);
        if (mode.clear_all_control)
        begin
            next_wr_ptr = '0; // R7
            next_rd_ptr = '0;
            next_level  = '0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level  <= next_level;
        end
        if (push)
        begin
            queue_mem[wr_ptr] <= word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and register reads
    always_comb
    begin
        events                      = '0;
        events[tic_pkg::EV_DATA]    = word_valid; // R9
        events[tic_pkg::EV_TIMEOUT] = timeout_pulse; // R6
        events[tic_pkg::EV_LOST]    = lost;
        next_int_status             = int_status;
        next_rdata                  = '0;
        if (reg_rd)
        begin
            if (reg_addr == tic_pkg::OFS_MODE)
            begin
                next_rdata = tic_pkg::DATA_W'(mode);
            end
            else if (reg_addr == tic_pkg::OFS_END)
            begin
                next_rdata = tic_pkg::DATA_W'(end_value);
            end
            else if (reg_addr == tic_pkg::OFS_QUEUE)
            begin
                next_rdata = pop ? word_to_bus(queue_mem[rd_ptr]) : '0; // R16
            end
            else if (reg_addr == tic_pkg::OFS_STATUS)
            begin
                next_rdata      = tic_pkg::DATA_W'(int_status);
                next_int_status = '0;
            end
            else if (reg_addr == tic_pkg::OFS_MASK)
            begin
                next_rdata = tic_pkg::DATA_W'(int_mask);
            end
            else if (reg_addr == tic_pkg::OFS_DMA_CTRL)
            begin
                next_rdata[tic_pkg::BIT_DMA_EN]   = dma_en;
                next_rdata[tic_pkg::BIT_DMA_WRAP] = dma_wrap;
            end
            else if (reg_addr == tic_pkg::OFS_DMA_BEG)
            begin
                next_rdata = tic_pkg::DATA_W'(dma_beg);
            end
            else if (reg_addr == tic_pkg::OFS_DMA_STOP)
            begin
                next_rdata = tic_pkg::DATA_W'(dma_stop);
            end
            else if (reg_addr == tic_pkg::OFS_DMA_CUR && DMA_CAPABLE)
            begin
                next_rdata = tic_pkg::DATA_W'(mem_wr_addr); // R14
            end
            else if (reg_addr == tic_pkg::OFS_LEVEL)
            begin
                next_rdata = tic_pkg::DATA_W'(level);
            end
        end
        // New events win over a read clear
        next_int_status = next_int_status | events; // R9
        if (mode.clear_all_control)
        begin
            next_int_status = '0; // R7
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            int_status <= '0;
            reg_rdata  <= '0;
        end
        else
        begin
            int_status <= next_int_status;
            reg_rdata  <= next_rdata;
        end
    end

    // Level interrupt from unmasked sticky bits
    assign irq = |(int_status & int_mask); // R9

endmodule

// ---- tb/tic_chk.sv ----
// Purpose: Port assertions for tic_top
// Assumes: Single core_clk domain
// Notes:   Bound to every tic_top
`timescale 1ns/1ps
module tic_chk
#(
    parameter bit DMA_CAPABLE = 1'b1,
    parameter int QUEUE_DEPTH = 8
)
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        cap_pin,
    input wire logic        irq,
    input wire logic        mem_wr_valid,
    input wire logic [14:0] mem_wr_addr,
    input wire logic [31:0] mem_wr_data,
    input wire logic        mem_wr_ready
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Stalled DMA write; mode write with clear-all
    sequence s_stall;
        mem_wr_valid && !mem_wr_ready;
    endsequence
    sequence s_clear;
        reg_wr && reg_addr == 8'h00 && reg_wdata[0];
    endsequence
    // Register port and interrupt
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside answer");
    a_queue_width: assert property (
        reg_rd && reg_addr == 8'h08 |=> reg_rdata[31:26] == 6'h00)
        else $error("queue word too wide");
    a_mask_off: assert property (
        reg_wr && reg_addr == 8'h10 && reg_wdata[2:0] == 3'h0 |=> !irq)
        else $error("irq with mask clear");
    a_clear_irq: assert property (s_clear |=> ##1 !irq)
        else $error("irq after clear-all");
    // DMA write side
    a_dma_hold: assert property (
        s_stall |=> mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
        else $error("dma write changed while stalled");
    a_one_flight: assert property (mem_wr_valid && mem_wr_ready |=> !mem_wr_valid)
        else $error("dma write back to back");
    a_dma_align: assert property (mem_wr_valid |-> mem_wr_addr[1:0] == 2'h0)
        else $error("dma address unaligned");
    a_dma_width: assert property (mem_wr_valid |-> mem_wr_data[31:26] == 6'h00)
        else $error("dma word too wide");
endmodule
bind tic_top tic_chk #(.DMA_CAPABLE(DMA_CAPABLE), .QUEUE_DEPTH(QUEUE_DEPTH)) u_tic_chk (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_pin(cap_pin), .irq(irq),
    .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_ready(mem_wr_ready));

// ---- tb/tic_mem_model.sv ----
// Purpose: Memory answering DMA writes
// Assumes: One write in flight
// Notes:   Stalls at random, logs every write
`timescale 1ns/1ps
module tic_mem_model
(
    input  wire logic        core_clk,
    input  wire logic        mem_wr_valid,
    input  wire logic [14:0] mem_wr_addr,
    input  wire logic [31:0] mem_wr_data,
    output logic             mem_wr_ready
);
    logic [14:0] addr_log[$];
    logic [31:0] data_log[$];
    initial mem_wr_ready = 1'b0;
    // Log writes; never stall twice in a row
    always @(posedge core_clk)
    begin
        if (mem_wr_valid && mem_wr_ready)
        begin
            addr_log.push_back(mem_wr_addr);
            data_log.push_back(mem_wr_data);
        end
        mem_wr_ready <= !mem_wr_ready | 1'($urandom % 2);
    end
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for tic_top
// Assumes: Memory model on the DMA side
// Notes:   Pulse widths random from a fixed seed
`timescale 1ns/1ps
module tb;
    logic        core_clk, rst_n, reg_wr, reg_rd, cap_pin, irq;
    logic        mem_wr_valid, mem_wr_ready;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_wr_data;
    logic [14:0] mem_wr_addr;
    int          n_errors, compares, i, w1, w2;
    logic [31:0] d;
    tic_top u_tic_top (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cap_pin(cap_pin), .irq(irq), .mem_wr_valid(mem_wr_valid),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready));
    tic_mem_model u_tic_mem_model (.core_clk(core_clk), .mem_wr_valid(mem_wr_valid),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready));
    // Core clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hold(input logic v, input int n);
        cap_pin <= v;
        repeat (n) @(posedge core_clk);
    endtask
    task automatic finish_test(input int extra = 0);
        n_errors += extra;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Words per run: timeouts every 7, closing words, two tail timeouts
    function automatic int n_words(input logic [1:0] e, input int a, input int b);
        return (e == 2'h0) ? 0 : (e == 2'h1) ? (a + 6) / 7 + (b + 6) / 7 + 2 : (a + b + 6) / 7 + 2;
    endfunction
    // One capture run in mode e, widths w1 then w2, optionally into DMA
    task automatic run_case(input logic [1:0] e, input int w1, input int w2, input bit dma);
        logic [31:0] v, s, q[$];
        logic        lvl;
        int          k;
        lvl = (e != 2'h2);
        cap_pin <= !lvl;
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h7);
        wr(8'h10, {31'h0, !dma});
        wr(8'h18, 32'h8103);
        wr(8'h1C, 32'h10C);
        wr(8'h14, {29'h0, dma, 1'b0, dma});
        rd(8'h18, v);
        chk(v, 32'h100);
        wr(8'h00, {27'h0, e, 3'h6});
        hold(!lvl, 3);
        hold(lvl, w1);
        hold(!lvl, w2);
        hold(lvl, 20);
        wr(8'h00, {27'h0, e, 3'h4});
        repeat (8) @(posedge core_clk);
        #1 k = 0;
        while (mem_wr_valid && k < 100)
            #10 k++;
        if (k == 100)
            finish_test(1);
        chk({31'h0, irq}, {31'h0, e != 2'h0 && !dma});
        @(posedge core_clk);
        rd(8'h0C, v);
        chk(v, {30'h0, {2{e != 2'h0}}});
        rd(8'h0C, v);
        chk(v, 32'h0);
        rd(8'h24, v);
        if (dma)
        begin
            chk(v, 32'h0);
            q = u_tic_mem_model.data_log;
            rd(8'h20, s);
            chk(s, 32'h100 + 4 * (q.size() % 3));
            for (k = 0; k < q.size(); k++)
                chk({17'h0, u_tic_mem_model.addr_log[k]}, 32'h100 + 4 * (k % 3));
        end
        for (k = 0; !dma && k < v; k++)
        begin
            rd(8'h08, s);
            q.push_back(s);
        end
        chk(q.size(), n_words(e, w1, w2));
        if (e == 2'h0 || q.size() == 0)
            return;
        chk(q[0], 32'h200_0007);
        s = 0;
        for (k = 0; k < q.size() && q[k][25]; k++)
            s += q[k][24:0];
        if (e != 2'h1)
        begin
            chk({31'h0, q[k][25]}, 32'h0);
            chk(s + q[k][24:0], w1 + w2);
            return;
        end
        chk(s, w1);
        for (s = 0; k < q.size() && !q[k][25]; k++)
            s += q[k][24:0];
        chk(s, w2);
    endtask
    // Reset, register reset values, then all capture modes
    initial
    begin
        {rst_n, reg_wr, reg_rd, cap_pin, reg_addr, reg_wdata} = '0;
        n_errors = 0;
        compares = 0;
        void'($urandom(32'h503f));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        wr(8'h28, 32'hFFFF_FFFF);
        for (i = 0; i < 11; i++)
        begin
            rd(8'(4 * i), d);
            chk(d, 32'h0);
        end
        for (i = 0; i < 5; i++)
        begin
            w1 = 10 + $urandom % 4;
            w2 = 3 + $urandom % 4;
            run_case(2'(i + 1), w1, w2, i == 4);
            $display("test %0d done", i);
        end
        finish_test();
    end
endmodule
